// ---- logic/smo_consts.svh ----
// constant defaults, encodings and timing counts for the speed monitor output logic
`ifndef SMO_CONSTS_SVH
`define SMO_CONSTS_SVH
`define SMO_CLK_HZ 100000000
`define SMO_TICK_MS 10
`define SMO_TICK_CYC ((`SMO_CLK_HZ / 1000) * `SMO_TICK_MS)
`define SMO_MODE_OVER 3'h0
`define SMO_MODE_UNDER 3'h1
`define SMO_MODE_STILL 3'h3
`define SMO_MODE_POSOVER 3'h4
`define SMO_ACT_FREEZE 4'h8
`define SMO_FUNC_OVERRIDE 4'h2
`define SMO_FUNC_RELEASE 4'h7
`define SMO_CFG_ACT_HIGH 1'h1
`define SMO_DISP_RPM 3'h3
`define SMO_RPM_FACTOR 32'h0000003C
`define SMO_WAIT_DEF 16'h01F4
`define SMO_STILL_DEF 16'h0064
`endif

// ---- logic/smo_pkg.sv ----
// types shared by the speed monitor output logic
package smo_pkg;
	typedef enum logic [1:0] {
		SMO_RUN,
		SMO_ZERO,
		SMO_STILL
	} smo_motion_t;
endpackage : smo_pkg

// ---- logic/smo_pulse_timer.sv ----
// one output channel: latch and timed pulse on the threshold condition
`timescale 1ns/1ps
module smo_pulse_timer
	import smo_pkg::*;
#(
	parameter int TW = 16
) (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic ce,
	input wire logic tick,
	input wire logic cond,
	input wire logic latch_en,
	input wire logic release_ev,
	input wire logic [TW-1:0] pulse_time,
	output logic active
);
	logic latch_q;
	logic level;
	logic level_prev_q;
	logic [TW-1:0] cnt_q;

	// latched output keeps its state after the condition clears
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			latch_q <= 1'b0;
		end else if (ce) begin
			if (cond && latch_en) begin
				latch_q <= 1'b1; // set wins over release
			end else if (release_ev) begin
				latch_q <= 1'b0;
			end
		end
	end

	assign level = cond || (latch_en && latch_q);

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			level_prev_q <= 1'b0;
			cnt_q <= '0;
		end else if (ce) begin
			level_prev_q <= level;
			if (level && !level_prev_q) begin
				cnt_q <= pulse_time; // one pulse per rising edge
			end else if (tick && cnt_q != '0) begin
				cnt_q <= cnt_q - 1'b1;
			end
		end
	end

	// pulse time counts in 10 ms ticks; zero means static output
	assign active = (pulse_time == '0) ? level : (cnt_q != '0);
endmodule : smo_pulse_timer

// ---- logic/smo_output_ctrl.sv ----
// output switching, override and freeze logic of the speed monitor
`timescale 1ns/1ps
`include "smo_consts.svh"
// Behaviour
// - override selection chooses outputs by weight; five selects outputs one and three
// - unselected outputs stay under normal threshold control during override
// - selected outputs follow the pattern bits; two keeps one and three off
// - selection eight freezes all outputs at their state when freeze began
// - while frozen, frequency changes do not affect the outputs
// - on command removal outputs return at once to threshold state
// - measurement and threshold evaluation keep running during override or freeze
// - up key starts override when its function value is two
// - control input one gives override or freeze when its function is two
// - control input one is active high when its configuration is one
// - mode three energizes output after standstill delay following zero frequency
// - mode one energizes when absolute speed is below switching point
// - mode four energizes only on positive speed above switching point
// - pulse time zero is static, otherwise a single timed pulse
// - polarity zero drives outputs non-inverted
// - start-up relay zero applies no start-up suppression
// - latch selection by weight gives catch behaviour; four latches output three
// - enter key or control input with function seven releases latches
// - zero frequency reported when no pulse arrives within wait time
// - standstill asserted after standstill time with no further pulse
// - display mode three expresses display and points in rpm
// - rpm equals sixty times frequency divided by pulses per revolution
module smo_output_ctrl
	import smo_pkg::*;
#(
	parameter int NOUT = 3,
	parameter int SW = 32,
	parameter int TW = 16,
	parameter int TICK_CYC = `SMO_TICK_CYC
) (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic ce,
	input wire logic freq_valid,
	input wire logic [SW-1:0] freq_hz,
	input wire logic dir_reverse,
	input wire logic pulse_in,
	input wire logic key_up,
	input wire logic key_enter,
	input wire logic ctrl_in1,
	input wire logic ctrl_in2,
	input wire logic [3:0] key_up_func,
	input wire logic [3:0] key_enter_func,
	input wire logic [3:0] in1_func,
	input wire logic [3:0] in2_func,
	input wire logic in1_cfg,
	input wire logic in2_cfg,
	input wire logic [3:0] relay_action,
	input wire logic [NOUT-1:0] action_polarity,
	input wire logic [NOUT-1:0] output_polarity,
	input wire logic [NOUT-1:0] startup_relay,
	input wire logic startup_active,
	input wire logic [NOUT-1:0] lock_relay,
	input wire logic [2:0] display_mode,
	input wire logic [SW-1:0] encoder_factor,
	input wire logic [TW-1:0] wait_time,
	input wire logic [TW-1:0] standstill_time,
	input wire logic [3*3-1:0] threshold_mode,
	input wire logic [3*SW-1:0] switch_point,
	input wire logic [3*TW-1:0] pulse_time,
	output logic output_one,
	output logic output_two,
	output logic output_three,
	output logic zero_freq,
	output logic standstill,
	output logic [SW-1:0] speed_value,
	output logic override_active,
	output logic freeze_active
);
	localparam int TCW = $clog2(TICK_CYC + 1);
	localparam logic [TCW-1:0] TICK_LAST = TCW'(TICK_CYC - 1);

	logic [1:0] pin1_q, pin2_q, pkup_q, pken_q, ppls_q;
	logic pls_prev_q;
	logic pulse_edge;
	logic in1_act, in2_act;
	logic cmd_on;
	logic release_ev;
	logic freeze_cmd;
	logic [TCW-1:0] tick_cnt_q;
	logic tick;
	logic [TW-1:0] idle_q;
	logic [TW-1:0] still_q;
	smo_motion_t motion_q;
	logic [SW-1:0] speed_q;
	logic [NOUT-1:0] thr_active;
	logic [NOUT-1:0] eval;
	logic [NOUT-1:0] out_d;
	logic [NOUT-1:0] frozen_q;
	logic freeze_q;
	logic ovr_q;

	// pins from outside pass two flip-flops
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			pin1_q <= 2'h0;
			pin2_q <= 2'h0;
			pkup_q <= 2'h0;
			pken_q <= 2'h0;
			ppls_q <= 2'h0;
		end else if (ce) begin
			pin1_q <= {pin1_q[0], ctrl_in1};
			pin2_q <= {pin2_q[0], ctrl_in2};
			pkup_q <= {pkup_q[0], key_up};
			pken_q <= {pken_q[0], key_enter};
			ppls_q <= {ppls_q[0], pulse_in};
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			pls_prev_q <= 1'b0;
		end else if (ce) begin
			pls_prev_q <= ppls_q[1];
		end
	end

	assign pulse_edge = ppls_q[1] && !pls_prev_q;
	assign in1_act = (in1_cfg == `SMO_CFG_ACT_HIGH) ? pin1_q[1] : !pin1_q[1];
	assign in2_act = (in2_cfg == `SMO_CFG_ACT_HIGH) ? pin2_q[1] : !pin2_q[1];
	// command is a level: edge-driven inputs would drop the override at once
	assign cmd_on = (pkup_q[1] && key_up_func == `SMO_FUNC_OVERRIDE) ||
		(in1_act && in1_func == `SMO_FUNC_OVERRIDE) ||
		(in2_act && in2_func == `SMO_FUNC_OVERRIDE);
	assign release_ev = (pken_q[1] && key_enter_func == `SMO_FUNC_RELEASE) ||
		(in1_act && in1_func == `SMO_FUNC_RELEASE) ||
		(in2_act && in2_func == `SMO_FUNC_RELEASE);
	assign freeze_cmd = cmd_on && (relay_action == `SMO_ACT_FREEZE);

	// 10 ms time base for wait, standstill and pulse times
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			tick_cnt_q <= '0;
		end else if (ce) begin
			if (tick_cnt_q == TICK_LAST) begin
				tick_cnt_q <= '0;
			end else begin
				tick_cnt_q <= tick_cnt_q + 1'b1;
			end
		end
	end
	assign tick = (tick_cnt_q == TICK_LAST);

	// zero frequency after wait time, standstill after a further standstill time
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			motion_q <= SMO_RUN;
			idle_q <= '0;
			still_q <= '0;
		end else if (ce) begin
			if (pulse_edge) begin
				motion_q <= SMO_RUN;
				idle_q <= '0;
				still_q <= '0;
			end else begin
				case (motion_q)
				SMO_RUN: begin
					if (tick) begin
						idle_q <= idle_q + 1'b1;
					end
					if (idle_q >= wait_time) begin
						motion_q <= SMO_ZERO;
					end
				end
				SMO_ZERO: begin
					if (tick) begin
						still_q <= still_q + 1'b1;
					end
					if (still_q >= standstill_time) begin
						motion_q <= SMO_STILL;
					end
				end
				SMO_STILL: begin
					motion_q <= SMO_STILL;
				end
				default: begin
					motion_q <= SMO_RUN;
				end
				endcase
			end
		end
	end

	// speed in display units; runs regardless of override
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			speed_q <= '0;
		end else if (ce && freq_valid) begin
			if (motion_q != SMO_RUN) begin
				speed_q <= '0;
			end else if (display_mode == `SMO_DISP_RPM && encoder_factor != '0) begin
				speed_q <= SW'((freq_hz * SW'(`SMO_RPM_FACTOR)) / encoder_factor);
			end else begin
				speed_q <= freq_hz;
			end
		end
	end

	genvar gi;
	generate
		for (gi = 0; gi < NOUT; gi++) begin : g_ch
			logic [2:0] mode;
			logic [SW-1:0] pt;
			logic cond;
			assign mode = threshold_mode[gi*3 +: 3];
			assign pt = switch_point[gi*SW +: SW];
			always_comb begin
				case (mode)
				`SMO_MODE_UNDER: begin
					cond = speed_q < pt; // speed is magnitude
				end
				`SMO_MODE_STILL: begin
					cond = motion_q == SMO_STILL;
				end
				`SMO_MODE_POSOVER: begin
					cond = !dir_reverse && speed_q > pt;
				end
				`SMO_MODE_OVER: begin
					cond = speed_q > pt;
				end
				default: begin
					cond = 1'b0;
				end
				endcase
			end
			smo_pulse_timer #(
				.TW(TW)
			) u_tim (
				.clk_sys(clk_sys),
				.rst(rst),
				.ce(ce),
				.tick(tick),
				.cond(cond),
				.latch_en(lock_relay[gi]),
				.release_ev(release_ev),
				.pulse_time(pulse_time[gi*TW +: TW]),
				.active(thr_active[gi])
			);
			// start-up suppression only for assigned outputs
			assign eval[gi] = (thr_active[gi] && !(startup_relay[gi] && startup_active))
				^ output_polarity[gi];
			always_comb begin
				if (freeze_q) begin
					out_d[gi] = frozen_q[gi];
				end else if (ovr_q && relay_action[gi]) begin
					out_d[gi] = action_polarity[gi];
				end else begin
					out_d[gi] = eval[gi];
				end
			end
		end
	endgenerate

	// snapshot taken on the cycle the freeze begins; the next-state value is
	// used so that the outputs do not step back one cycle when the hold starts
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			freeze_q <= 1'b0;
			ovr_q <= 1'b0;
			frozen_q <= '0;
		end else if (ce) begin
			freeze_q <= freeze_cmd;
			ovr_q <= cmd_on && !freeze_cmd;
			if (freeze_cmd && !freeze_q) begin
				frozen_q <= out_d;
			end
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			output_one <= 1'b0;
			output_two <= 1'b0;
			output_three <= 1'b0;
			zero_freq <= 1'b0;
			standstill <= 1'b0;
			speed_value <= '0;
			override_active <= 1'b0;
			freeze_active <= 1'b0;
		end else if (ce) begin
			output_one <= out_d[0];
			output_two <= out_d[1];
			output_three <= out_d[2];
			zero_freq <= motion_q != SMO_RUN;
			standstill <= motion_q == SMO_STILL;
			speed_value <= speed_q;
			override_active <= ovr_q;
			freeze_active <= freeze_q;
		end
	end
endmodule : smo_output_ctrl

// ---- test/smo_field.sv ----
// field side model: encoder pulses, front keys and remote control input
`timescale 1ns/1ps
module smo_field (
	input wire logic clk_sys,
	input wire logic run,
	input wire logic cmd_up,
	input wire logic cmd_enter,
	input wire logic cmd_in1,
	input wire logic in1_cfg,
	output logic pulse_in = 1'b0,
	output logic key_up,
	output logic key_enter,
	output logic ctrl_in1
);
	logic [4:0] cnt_q = 5'h0;
	// commands held as plain levels, edges alone would be lost
	assign key_up = cmd_up;
	assign key_enter = cmd_enter;
	assign ctrl_in1 = ~(cmd_in1 ^ in1_cfg);
	always_ff @(posedge clk_sys) begin
		cnt_q <= (cnt_q == 5'h13) ? 5'h0 : cnt_q + 5'h1;
		pulse_in <= run && cnt_q == 5'h0;
	end
endmodule : smo_field

// ---- test/smo_output_ctrl_chk.sv ----
// assertions on override, freeze and standstill behaviour
`timescale 1ns/1ps
module smo_output_ctrl_chk #(
	parameter int NOUT = 3
) (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic ctrl_in1,
	input wire logic key_up,
	input wire logic [3:0] key_up_func,
	input wire logic [3:0] in1_func,
	input wire logic in1_cfg,
	input wire logic [3:0] relay_action,
	input wire logic [NOUT-1:0] action_polarity,
	input wire logic output_one,
	input wire logic output_two,
	input wire logic output_three,
	input wire logic zero_freq,
	input wire logic standstill,
	input wire logic override_active,
	input wire logic freeze_active
);
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (rst);
	a_reset_clear: assert property ($fell(rst) |-> !(output_one | output_two | output_three
		| override_active | freeze_active)) else $error("outputs not clear after reset");
	a_ovr_pat_one: assert property (override_active && $past(override_active) && !freeze_active
		&& relay_action[0] |-> output_one == action_polarity[0]) else $error("pattern one");
	a_ovr_pat_three: assert property (override_active && $past(override_active) && !freeze_active
		&& relay_action[2] |-> output_three == action_polarity[2]) else $error("pattern three");
	a_freeze_hold: assert property (freeze_active
		|-> $stable({output_one, output_two, output_three})) else $error("frozen output moved");
	a_freeze_code: assert property (freeze_active |-> relay_action == 4'h8) else $error("freeze");
	a_in1_cmd: assert property ((in1_func == 4'h2 && ctrl_in1 == in1_cfg
		&& relay_action != 4'h8) [*5] |=> override_active) else $error("input one ignored");
	a_up_cmd: assert property ((key_up_func == 4'h2 && key_up && relay_action != 4'h8) [*5]
		|=> override_active) else $error("up key ignored");
	a_cmd_drop: assert property (((in1_func != 4'h2 || ctrl_in1 != in1_cfg)
		&& (key_up_func != 4'h2 || !key_up)) [*5] |=> !override_active && !freeze_active)
		else $error("override outlives command");
	a_still_order: assert property ($rose(standstill) |-> zero_freq && $past(zero_freq))
		else $error("standstill before zero");
	c_ovr: cover property ($rose(override_active));
	c_frz: cover property ($rose(freeze_active));
	c_still: cover property ($rose(standstill));
endmodule : smo_output_ctrl_chk

// ---- test/tb.sv ----
// self-checking bench for the speed monitor output logic
`timescale 1ns/1ps
module tb;
	import smo_pkg::*;
	logic clk_sys = 0, rst = 1, ce = 1, freq_valid = 1, dir_reverse = 0, ctrl_in2 = 0;
	logic in2_cfg = 0, in1_cfg = 1, startup_active = 0, run = 1, cmd_up = 0, cmd_enter = 0;
	logic cmd_in1 = 0, pulse_in, key_up, key_enter, ctrl_in1, output_one, output_two;
	logic output_three, zero_freq, standstill, override_active, freeze_active;
	logic [3:0] key_up_func = 4'h0, key_enter_func = 4'h7, in1_func = 4'h7, in2_func = 4'h0;
	logic [3:0] relay_action = 4'h5;
	logic [2:0] action_polarity = 3'h2, output_polarity = 3'h0, startup_relay = 3'h0;
	logic [2:0] lock_relay = 3'h4, display_mode = 3'h3, snap;
	logic [31:0] freq_hz = 32'h0, encoder_factor = 32'h20, speed_value, seed = 32'h0000BCCC, tmp;
	logic [15:0] wait_time = 16'h0005, standstill_time = 16'h0003;
	logic [8:0] threshold_mode = 9'h10B;
	logic [95:0] switch_point = {32'h12C, 32'h64, 32'h0};
	logic [47:0] pulse_time = {16'h0, 16'h3, 16'h0};
	int fail_count = 0, num_checks = 0;
	smo_output_ctrl #(.TICK_CYC(10)) dut_u (.*);
	smo_field field_u (.*);
	always #5 clk_sys = ~clk_sys;
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : rnd
	function automatic logic [31:0] rpm();
		return 32'h3C * freq_hz / encoder_factor;
	endfunction : rpm
	// expected outputs under plain threshold control, no latch; pulses keep
	// arriving whenever this is used, so the standstill output stays off
	function automatic logic [2:0] norm();
		return {!dir_reverse && rpm() > 32'h12C, rpm() < 32'h64, 1'b0};
	endfunction : norm
	task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
		num_checks++;
		if (seen !== exp) begin
			fail_count++;
			$display("MISMATCH %0t %s", $time, what);
		end
	endtask : check
	task automatic cyc(input int n);
		repeat (n) @(posedge clk_sys);
		#1;
	endtask : cyc
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", num_checks, fail_count);
		if (fail_count == 0 && num_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : wrap_up
	task automatic wait_hi(ref logic s);
		for (int i = 0; i < 300 && s !== 1'b1; i++) cyc(1);
		if (s !== 1'b1) begin
			fail_count++;
			$display("MISMATCH %0t wait ran out", $time);
			wrap_up();
		end
	endtask : wait_hi
	initial begin
		cyc(10);
		rst = 0;
		for (int i = 0; i < 6; i++) begin
			freq_hz = rnd() % 32'h4E20;
			cyc(4);
			check(speed_value, rpm(), "rpm");
		end
		tmp = rpm();
		ce = 0;
		freq_hz = 32'h3E8;
		cyc(4);
		check(speed_value, tmp, "hold on ce low");
		ce = 1;
		cyc(4);
		check(speed_value, rpm(), "rpm after ce");
		$display("speed done");
		for (int k = 0; k < 2; k++) begin
			freq_hz = 32'hD6;
			dir_reverse = 0;
			cyc(8);
			check(output_three, 1, "overspeed");
			dir_reverse = 1;
			cyc(8);
			check(output_three, 1, "catch");
			cmd_in1 = k == 0;
			cmd_enter = k == 1;
			cyc(8);
			check(output_three, 0, "release");
			cmd_in1 = 0;
			cmd_enter = 0;
		end
		freq_hz = 32'h10;
		wait_hi(output_two);
		cyc(15);
		check(output_two, 1, "pulse");
		cyc(20);
		check(output_two, 0, "pulse end");
		pulse_time = 48'h0;
		cyc(40);
		check(output_two, 1, "static");
		$display("threshold done");
		lock_relay = 3'h0;
		in1_func = 4'h2;
		key_up_func = 4'h2;
		dir_reverse = 0;
		for (int k = 0; k < 6; k++) begin
			tmp = rnd();
			relay_action = k == 0 ? 4'h5 : {1'b0, tmp[2:0] | 3'h1};
			action_polarity = k == 0 ? 3'h2 : tmp[5:3];
			cmd_in1 = k % 2 == 0;
			cmd_up = k % 2 == 1;
			cyc(6);
			freq_hz = tmp[6] ? 32'hD6 : 32'h10;
			cyc(8);
			snap = (relay_action[2:0] & action_polarity) | (~relay_action[2:0] & norm());
			check(override_active, 1, "override on");
			check({output_three, output_two, output_one}, snap, "override");
			check(speed_value, rpm(), "rpm in override");
			cmd_in1 = 0;
			cmd_up = 0;
			cyc(6);
			check({output_three, output_two, output_one}, norm(), "return");
		end
		$display("override done");
		relay_action = 4'h8;
		action_polarity = 3'h7;
		freq_hz = 32'h10;
		cyc(8);
		cmd_in1 = 1;
		cyc(6);
		check(freeze_active, 1, "freeze on");
		snap = {output_three, output_two, output_one};
		freq_hz = 32'hD6;
		cyc(10);
		check({output_three, output_two, output_one}, snap, "frozen");
		check(speed_value, rpm(), "rpm in freeze");
		cmd_in1 = 0;
		cyc(6);
		check({output_three, output_two, output_one}, norm(), "thaw");
		threshold_mode = 9'h00B;
		dir_reverse = 1;
		cyc(6);
		check(output_three, 1, "overspeed any direction");
		threshold_mode = 9'h10B;
		cyc(6);
		check(output_three, 0, "no reverse response");
		$display("freeze done");
		wait_hi(pulse_in);
		run = 0;
		cyc(35);
		check(zero_freq, 0, "early zero");
		cyc(35);
		check(zero_freq, 1, "zero");
		cyc(45);
		check({standstill, output_one}, 2'h3, "standstill");
		$display("standstill done");
		wrap_up();
	end
endmodule : tb
bind smo_output_ctrl smo_output_ctrl_chk #(.NOUT(NOUT)) chk_u (.clk_sys, .rst, .ctrl_in1, .key_up,
	.key_up_func, .in1_func, .in1_cfg, .relay_action, .action_polarity, .output_one, .output_two,
	.output_three, .zero_freq, .standstill, .override_active, .freeze_active);
